/* File: design/core_regs_pkg.sv */
// Package with register map, reset values and state codes of the core register block
package core_regs_pkg;
  localparam int          ADDR_W          = 12;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_STACK_PTR   = 8'h81;
  localparam logic [7:0]  IDX_SIXTEEN_BIT_DATA_POINTER_LOW    = 8'h82;
  localparam logic [7:0]  IDX_SIXTEEN_BIT_DATA_POINTER_HIGH   = 8'h83;
  localparam logic [7:0]  IDX_ACCUM       = 8'he0;
  localparam logic [7:0]  IDX_SECOND      = 8'hf0;
  localparam logic [7:0]  IDX_PUSH_DATA   = 8'h90;
  localparam logic [7:0]  IDX_POP_CMD     = 8'h91;
  localparam logic [7:0]  IDX_POP_RESULT  = 8'h92;
  localparam logic [7:0]  IDX_BIT_OP      = 8'h93;
  localparam logic [7:0]  IDX_STATUS      = 8'h94;
  // Reset values
  localparam logic [7:0]  RST_STACK_PTR   = 8'h07;
  localparam logic [7:0]  RST_SIXTEEN_BIT_DATA_POINTER_LOW    = 8'h00;
  localparam logic [7:0]  RST_SIXTEEN_BIT_DATA_POINTER_HIGH   = 8'h00;
  localparam logic [7:0]  RST_ACCUM       = 8'h00;
  localparam logic [7:0]  RST_SECOND      = 8'h00;
  localparam logic [7:0]  RST_POP_RESULT  = 8'h00;
  // Bit operation fields
  localparam int          BITOP_IDX_LSB   = 0;
  localparam int          BITOP_VAL_POS   = 3;
  localparam int          BITOP_SEL_POS   = 4;
  // Status fields
  localparam int          STAT_BUSY_POS   = 0;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  typedef enum logic [4:0] {
    st_idle     = 5'h01,
    st_push_inc = 5'h02,
    st_push_wr  = 5'h04,
    st_pop_rd   = 5'h08,
    st_pop_cap  = 5'h10
  } stack_state_t;
endpackage

/* File: design/stack_ram.sv */
// Internal data memory holding the stack, registered read port
`timescale 1ns/1ns
`default_nettype none
module stack_ram (
  input  wire logic       clock,
  input  wire logic       we,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output var  logic [7:0] rdata
);
  logic [7:0] mem [0:255];

  // No reset: contents are undefined until written, like real RAM
  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

/* File: design/core_regs.sv */
// Core pointer, stack and accumulator registers behind an AXI4-Lite slave
// Functional notes
// - High byte register forms the upper half of the 16-bit data pointer.
// - High byte register: 8-bit RW, index 0x83, resets to zero.
// - Stack pointer always addresses current top of stack in internal memory.
// - Push increments stack pointer first, then writes byte at new address.
// - Stack pointer resets to 0x07, first push lands at 0x08.
// - Accumulator: primary arithmetic operand, 8-bit RW, resets to zero.
// - Accumulator at index 0xE0, each bit individually addressable.
// - Second operand register: auxiliary accumulator, 8-bit RW, resets zero.
// - Second operand register at index 0xF0, bit-addressable.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module core_regs
  import core_regs_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [15:0]            sixteen_bit_data_pointer,
  output var  logic [7:0]        stack_top_pointer,
  output var  logic [7:0]        primary_accumulator,
  output var  logic [7:0]        second_operand
);

  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[9:2];
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    is_mapped = (a[ADDR_W-1:10] == '0) && (a[1:0] == 2'h0) &&
                ((i == IDX_STACK_PTR) || (i == IDX_SIXTEEN_BIT_DATA_POINTER_LOW) ||
                 (i == IDX_SIXTEEN_BIT_DATA_POINTER_HIGH) || (i == IDX_ACCUM) ||
                 (i == IDX_SECOND) || (i == IDX_PUSH_DATA) ||
                 (i == IDX_POP_CMD) || (i == IDX_POP_RESULT) ||
                 (i == IDX_BIT_OP) || (i == IDX_STATUS));
  endfunction

  logic [7:0]        data_pointer_low;
  logic [7:0]        data_pointer_high;
  logic [7:0]        pop_result;
  logic [7:0]        push_byte;
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_full;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_full;
  stack_state_t      state;
  stack_state_t      next_state;
  logic [7:0]        ram_rdata;

  // Both halves come straight from their flip-flops
  assign sixteen_bit_data_pointer = {data_pointer_high, data_pointer_low};

  // Write decode
  wire        wr_go      = aw_full && w_full && !s_axi_bvalid && (state == st_idle);
  wire [7:0]  wr_idx     = reg_index(aw_addr);
  wire        wr_ok      = is_mapped(aw_addr);
  wire        wr_lane0   = w_strb[0];
  wire [7:0]  wr_byte    = w_data[7:0];
  wire        wr_en      = wr_go && wr_ok && wr_lane0;
  wire        wr_sp      = wr_en && (wr_idx == IDX_STACK_PTR);
  wire        wr_dpl     = wr_en && (wr_idx == IDX_SIXTEEN_BIT_DATA_POINTER_LOW);
  wire        wr_dph     = wr_en && (wr_idx == IDX_SIXTEEN_BIT_DATA_POINTER_HIGH);
  wire        wr_acc     = wr_en && (wr_idx == IDX_ACCUM);
  wire        wr_sec     = wr_en && (wr_idx == IDX_SECOND);
  wire        wr_push    = wr_en && (wr_idx == IDX_PUSH_DATA);
  wire        wr_pop     = wr_en && (wr_idx == IDX_POP_CMD);
  wire        wr_bitop   = wr_en && (wr_idx == IDX_BIT_OP);
  wire [2:0]  bit_idx    = wr_byte[BITOP_IDX_LSB +: 3];
  wire        bit_val    = wr_byte[BITOP_VAL_POS];
  wire        bit_sec    = wr_byte[BITOP_SEL_POS];
  wire        bit_acc_en = wr_bitop && !bit_sec;
  wire        bit_sec_en = wr_bitop && bit_sec;
  // Stack operations answer only when finished, so the response is deferred
  wire        wr_stack   = wr_push || wr_pop;
  wire        wr_done    = (wr_go && !wr_stack) || (state == st_push_wr) || (state == st_pop_cap);
  wire        busy       = (state != st_idle);

  // Bit update helper: one bit replaced, others kept
  function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] n, input logic b);
    logic [7:0] r;
    r = v;
    r[n] = b;
    set_bit = r;
  endfunction

  // Read decode
  wire        rd_go      = s_axi_arvalid && s_axi_arready;
  wire [7:0]  rd_idx     = reg_index(s_axi_araddr);
  wire        rd_ok      = is_mapped(s_axi_araddr);
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      IDX_STACK_PTR:  rd_byte = stack_top_pointer;
      IDX_SIXTEEN_BIT_DATA_POINTER_LOW:   rd_byte = data_pointer_low;
      IDX_SIXTEEN_BIT_DATA_POINTER_HIGH:  rd_byte = data_pointer_high;
      IDX_ACCUM:      rd_byte = primary_accumulator;
      IDX_SECOND:     rd_byte = second_operand;
      IDX_POP_RESULT: rd_byte = pop_result;
      IDX_STATUS:     rd_byte = {7'h00, busy};
      default:        rd_byte = 8'h00;
    endcase
  end

  // Stack sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (wr_push) begin
          next_state = st_push_inc;
        end else if (wr_pop) begin
          next_state = st_pop_rd;
        end
      end
      st_push_inc: next_state = st_push_wr;
      st_push_wr:  next_state = st_idle;
      st_pop_rd:   next_state = st_pop_cap;
      st_pop_cap:  next_state = st_idle;
      default:     next_state = st_idle;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // Memory address is always the stack pointer
  wire ram_we = (state == st_push_wr);

  stack_ram u_ram (
    .clock (clock),
    .we    (ram_we),
    .addr  (stack_top_pointer),
    .wdata (push_byte),
    .rdata (ram_rdata)
  );

  // Stack pointer: direct writes, pre-increment on push, post-decrement on pop
  always_ff @(posedge clock) begin
    if (!rstn) begin
      stack_top_pointer <= RST_STACK_PTR;
    end else if (wr_sp) begin
      stack_top_pointer <= wr_byte;
    end else if (state == st_push_inc) begin
      stack_top_pointer <= stack_top_pointer + 8'h01;
    end else if (state == st_pop_cap) begin
      stack_top_pointer <= stack_top_pointer - 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      push_byte <= 8'h00;
    end else if (wr_push) begin
      push_byte <= wr_byte;
    end
  end

  // Registered read data is valid in the capture state
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pop_result <= RST_POP_RESULT;
    end else if (state == st_pop_cap) begin
      pop_result <= ram_rdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      data_pointer_low  <= RST_SIXTEEN_BIT_DATA_POINTER_LOW;
      data_pointer_high <= RST_SIXTEEN_BIT_DATA_POINTER_HIGH;
    end else begin
      if (wr_dpl) begin
        data_pointer_low <= wr_byte;
      end
      if (wr_dph) begin
        data_pointer_high <= wr_byte;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      primary_accumulator <= RST_ACCUM;
    end else if (wr_acc) begin
      primary_accumulator <= wr_byte;
    end else if (bit_acc_en) begin
      primary_accumulator <= set_bit(primary_accumulator, bit_idx, bit_val);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      second_operand <= RST_SECOND;
    end else if (wr_sec) begin
      second_operand <= wr_byte;
    end else if (bit_sec_en) begin
      second_operand <= set_bit(second_operand, bit_idx, bit_val);
    end
  end

  // Write address and data are held independently until the response is taken
  always_ff @(posedge clock) begin
    if (!rstn) begin
      aw_full       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_full       <= 1'b0;
      s_axi_awready <= 1'b1;
    end else begin
      s_axi_awready <= !aw_full;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      w_full       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_full       <= 1'b0;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_wready <= !w_full;
    end
  end

  // Error is known at the start; response is raised when the write completes
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_done) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (state != st_idle || wr_ok) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // One read in flight; arready drops until rdata is taken
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_ok ? {24'h000000, rd_byte} : 32'h00000000;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

endmodule
`default_nettype wire

/* File: verif/core_regs_sva.sv */
// Concurrent checks on the core register block ports
`timescale 1ns/1ns
`default_nettype none
module core_regs_sva (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_bvalid,
  input wire logic [15:0] sixteen_bit_data_pointer,
  input wire logic [7:0]  stack_top_pointer,
  input wire logic [7:0]  primary_accumulator,
  input wire logic [7:0]  second_operand
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_RESET_VALUES: assert property (
    $rose(rstn) |-> stack_top_pointer == 8'h07 && sixteen_bit_data_pointer == 16'h0000
      && primary_accumulator == 8'h00 && second_operand == 8'h00) else $error("reset values wrong");
  AST_SIXTEEN_BIT_DATA_POINTER_WRITE: assert property (
    $changed(sixteen_bit_data_pointer) |-> $rose(s_axi_bvalid)) else $error("pointer changed unasked");
  AST_ACC_WRITE: assert property (
    $changed(primary_accumulator) |-> $rose(s_axi_bvalid)) else $error("accumulator changed unasked");
  AST_SECOND_WRITE: assert property (
    $changed(second_operand) |-> $rose(s_axi_bvalid)) else $error("second operand changed unasked");
  AST_PUSH_INC: assert property (
    $changed(stack_top_pointer) && !$rose(s_axi_bvalid)
      |-> stack_top_pointer == $past(stack_top_pointer) + 8'h01 ##1 $rose(s_axi_bvalid))
    else $error("push step not an increment before response");
  AST_STACK_CHANGE: assert property (
    $changed(stack_top_pointer) |-> ##[0:1] $rose(s_axi_bvalid)) else $error("stack pointer moved unasked");
  AST_READ_ACC: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h380
      |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(primary_accumulator)}) else $error("accumulator read wrong");
  AST_READ_STACK: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h204
      |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(stack_top_pointer)}) else $error("stack read wrong");
endmodule
bind core_regs core_regs_sva chk (.*);
`default_nettype wire

/* File: verif/test_cpu_core_pointer_accumulator_regs.sv */
// Self-checking bench for the core register block
`timescale 1ns/1ns
`default_nettype none
module test_cpu_core_pointer_accumulator_regs;
  import core_regs_pkg::*;
  logic        clock = 1'b0, rstn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  // Lane zero strobe of the next write; cleared to prove a masked write is ignored
  logic        wr_lane0 = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0] sixteen_bit_data_pointer;
  logic [7:0]  stack_top_pointer, primary_accumulator, second_operand;
  logic [33:0] exp_q[$];
  int          num_errors = 0, n_compared = 0, cycles = 0;
  core_regs uut (.*);
  always #50 clock = ~clock;
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  task automatic check(input logic [33:0] got, input logic [33:0] want);
    n_compared++;
    if (got !== want) begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic conclude();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Results are matched in issue order; only one transfer is ever open
  always @(posedge clock) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready) check({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid === 1'b1 && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
  // Leading edge keeps a release and the next request out of one time step
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge clock);
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'($urandom()), d};
    s_axi_wstrb <= {3'($urandom()), wr_lane0};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge clock);
    exp_q.push_back({r, 24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  initial begin
    logic [7:0] idx[5];
    logic [7:0] rst_v[5];
    logic [7:0] v[5];
    idx = '{IDX_STACK_PTR, IDX_SIXTEEN_BIT_DATA_POINTER_LOW, IDX_SIXTEEN_BIT_DATA_POINTER_HIGH, IDX_ACCUM, IDX_SECOND};
    rst_v = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
    void'($urandom(32'hefc7));
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(ba(idx[i]), rst_v[i], RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      v[i] = 8'($urandom());
      wr(ba(idx[i]), v[i], RESP_OKAY);
    end
    for (int i = 0; i < 5; i++) rd(ba(idx[i]), v[i], RESP_OKAY);
    check({18'h0, sixteen_bit_data_pointer}, {18'h0, v[2], v[1]});
    wr(ba(IDX_STACK_PTR), 8'h07, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      wr(ba(IDX_PUSH_DATA), v[i + 3], RESP_OKAY);
      rd(ba(IDX_STACK_PTR), 8'(8 + i), RESP_OKAY);
    end
    for (int i = 1; i >= 0; i--) begin
      wr(ba(IDX_POP_CMD), 8'h00, RESP_OKAY);
      rd(ba(IDX_POP_RESULT), v[i + 3], RESP_OKAY);
      rd(ba(IDX_STACK_PTR), 8'(7 + i), RESP_OKAY);
    end
    wr(ba(IDX_ACCUM), 8'h00, RESP_OKAY);
    wr(ba(IDX_SECOND), 8'hff, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      wr(ba(IDX_BIT_OP), 8'(8 + i), RESP_OKAY);
      wr(ba(IDX_BIT_OP), 8'(16 + i), RESP_OKAY);
      rd(ba(IDX_ACCUM), 8'((2 << i) - 1), RESP_OKAY);
      rd(ba(IDX_SECOND), 8'(8'hff << (i + 1)), RESP_OKAY);
    end
    wr(12'h100, 8'h5a, RESP_SLVERR);
    rd(12'h100, 8'h00, RESP_SLVERR);
    wr(12'h381, 8'h5a, RESP_SLVERR);
    wr(ba(IDX_POP_RESULT), 8'h5a, RESP_OKAY);
    rd(ba(IDX_ACCUM), 8'hff, RESP_OKAY);
    wr_lane0 = 1'b0;
    wr(ba(IDX_ACCUM), 8'h00, RESP_OKAY);
    wr_lane0 = 1'b1;
    rd(ba(IDX_ACCUM), 8'hff, RESP_OKAY);
    rd(ba(IDX_STATUS), 8'h00, RESP_OKAY);
    check({26'h0, primary_accumulator}, {26'h0, 8'hff});
    check({26'h0, second_operand}, 34'h0);
    check({26'h0, stack_top_pointer}, {26'h0, 8'h07});
    wr(ba(IDX_STACK_PTR), 8'h3c, RESP_OKAY);
    // Second reset between transfers, so no answer is lost in flight
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rd(ba(IDX_STACK_PTR), 8'h07, RESP_OKAY);
    rd(ba(IDX_ACCUM), 8'h00, RESP_OKAY);
    rd(ba(IDX_SIXTEEN_BIT_DATA_POINTER_HIGH), 8'h00, RESP_OKAY);
    check({18'h0, sixteen_bit_data_pointer}, 34'h0);
    conclude();
  end
endmodule
`default_nettype wire
